// [core/fpu_deferred_exception_signal.sv]
`default_nettype none
module fpu_deferred_exception_signal
    import fpu_exc_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // instruction issue from the core
    input  wire logic        i_insn_valid,
    input  wire logic [3:0]  i_insn_kind,
    input  wire logic [31:0] i_insn_ptr,
    input  wire logic [31:0] i_operand_ptr,
    input  wire logic        i_stack_overflow,
    input  wire logic        i_stack_underflow,
    input  wire logic [15:0] i_image_status,
    input  wire logic [15:0] i_image_control,
    output logic             o_insn_done,
    output logic             o_stall,
    // numeric exception detection
    input  wire logic        i_exc_detect,
    input  wire logic [5:0]  i_exc_flags,
    input  wire logic        i_ignore_numeric_error_n,
    // handler entry
    input  wire logic        i_handler_entry,
    input  wire logic [1:0]  i_entry_src,
    input  wire logic        i_ext_int_enable,
    output logic             o_handler_request,
    output logic             o_ext_int_disabled,
    output logic             o_error_n,
    // state and save image
    output logic [15:0]      o_status_word,
    output logic [5:0]       o_control_masks,
    output logic [31:0]      o_insn_ptr_saved,
    output logic [31:0]      o_operand_ptr_saved,
    output logic             o_save_strobe,
    output logic [9:0]       o_save_bytes
);
    status_if      st ();
    freeze_state_e state;
    insn_kind_e    kind;
    logic          hold_off;
    logic          accept;

    exception_status u_status (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .st      (st.keeper)
    );

    assign kind     = insn_kind_e'(i_insn_kind);
    // freeze only waiting forms, and only while the ignore input is released
    assign hold_off = is_waiting(kind) && st.pending && i_ignore_numeric_error_n; // RQ2 RQ3
    assign accept   = (state == ST_RUN) && i_insn_valid && !o_insn_done && !hold_off;

    always_comb
    begin
        st.detect          = i_exc_detect;
        st.detect_flags    = i_exc_flags;
        st.set_stack_fault = accept && (kind == K_ARITH) &&
                             (i_stack_overflow || i_stack_underflow); // RQ1
        st.clear_flags     = accept && (kind == K_CLEAR);
        st.reinit          = accept && ((kind == K_INIT) || (kind == K_FULL_SAVE)); // RQ6
        st.mask_all        = accept && (kind == K_ENV_SAVE); // RQ6
        st.load            = accept && ((kind == K_FULL_RESTORE) ||
                                        (kind == K_ENV_RESTORE)); // RQ7
        st.load_flags      = i_image_status[NUM_FLAGS-1:0];
        st.load_sf         = i_image_status[SW_SF_BIT];
        st.load_masks_en   = accept && (kind == K_LOAD_CTRL);
        st.load_masks      = i_image_control[NUM_FLAGS-1:0];
    end

    // freeze sequencing
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state             <= ST_RUN;
            o_stall           <= 1'b0;
            o_handler_request <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (i_insn_valid && !o_insn_done && hold_off && !i_handler_entry)
                    begin
                        state             <= ST_FROZEN; // RQ2
                        o_stall           <= 1'b1;
                        o_handler_request <= 1'b1;
                    end
                end
                ST_FROZEN:
                begin
                    if (i_handler_entry)
                    begin
                        state             <= ST_RUN; // RQ4
                        o_stall           <= 1'b0;
                        o_handler_request <= 1'b0;
                    end
                end
                default:
                begin
                    state             <= ST_RUN;
                    o_stall           <= 1'b0;
                    o_handler_request <= 1'b0;
                end
            endcase
        end
    end

    // the core may enter the handler early; the disable holds until software re-enables
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_ext_int_disabled <= 1'b0;
        end
        else if (i_handler_entry && (entry_src_e'(i_entry_src) != SRC_NONE))
        begin
            o_ext_int_disabled <= 1'b1; // RQ5
        end
        else if (i_ext_int_enable)
        begin
            o_ext_int_disabled <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_insn_done <= 1'b0;
        end
        else
        begin
            o_insn_done <= accept;
        end
    end

    // pointer capture at the start of each numeric instruction
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_insn_ptr_saved    <= PTR_RESET;
            o_operand_ptr_saved <= PTR_RESET;
        end
        else if (accept && (kind == K_ARITH))
        begin
            o_insn_ptr_saved    <= i_insn_ptr; // RQ11
            o_operand_ptr_saved <= i_operand_ptr; // RQ11
        end
    end

    // save image size; status word below still shows the state before reinit
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_save_strobe <= 1'b0;
            o_save_bytes  <= NO_SAVE_BYTES;
        end
        else
        begin
            o_save_strobe <= accept && ((kind == K_FULL_SAVE) || (kind == K_ENV_SAVE) ||
                                        (kind == K_EXT_SAVE));
            if (accept && (kind == K_FULL_SAVE))
            begin
                o_save_bytes <= FULL_SAVE_BYTES; // RQ8
            end
            else if (accept && (kind == K_ENV_SAVE))
            begin
                o_save_bytes <= ENV_SAVE_BYTES; // RQ9
            end
            else if (accept && (kind == K_EXT_SAVE))
            begin
                o_save_bytes <= EXT_SAVE_BYTES;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_status_word   <= {SW_UPPER_ZERO, 2'b00, FLAGS_CLEAR};
            o_control_masks <= MASK_ALL;
            o_error_n       <= 1'b1;
        end
        else
        begin
            o_status_word   <= {SW_UPPER_ZERO, st.pending, st.stack_fault, st.flags};
            o_control_masks <= st.masks;
            o_error_n       <= !st.pending; // RQ12 RQ13
        end
    end

    stall_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ2
        (state == ST_RUN && i_insn_valid && !o_insn_done && hold_off && !i_handler_entry)
            |=> o_stall && o_handler_request && !o_insn_done)
        else $error("waiting instruction ran past a pending exception");
    ignore_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ3
        (state == ST_RUN && i_insn_valid && !o_insn_done &&
         (!i_ignore_numeric_error_n || !is_waiting(kind))) |=> o_insn_done && !o_stall)
        else $error("ignored or no-wait instruction was frozen");
    frozen_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
        (o_stall && !i_handler_entry) |=> o_stall && o_handler_request)
        else $error("freeze released before handler entry");
    int_disable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ5
        (i_handler_entry && i_entry_src != SRC_NONE) |=> o_ext_int_disabled)
        else $error("interrupts not disabled on handler entry");
    full_save_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ6 RQ8
        (accept && kind == K_FULL_SAVE && !i_exc_detect) |=>
            (o_save_strobe && o_save_bytes == FULL_SAVE_BYTES) ##1
            (o_status_word[NUM_FLAGS-1:0] == FLAGS_CLEAR && o_control_masks == MASK_ALL))
        else $error("full save did not size or reinitialise");
    env_save_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ6 RQ9
        (accept && kind == K_ENV_SAVE) |=>
            (o_save_bytes == ENV_SAVE_BYTES) ##1 (o_control_masks == MASK_ALL))
        else $error("environment save did not size or mask");
    restore_raise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ7 RQ12
        (accept && st.load && |(i_image_status[NUM_FLAGS-1:0] &
                                ~i_image_control[NUM_FLAGS-1:0]))
            |-> ##2 !o_error_n)
        else $error("restore of unmasked flag raised no request");
    pointer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ11
        (accept && kind == K_ARITH) |=>
            (o_insn_ptr_saved == $past(i_insn_ptr) &&
             o_operand_ptr_saved == $past(i_operand_ptr)))
        else $error("instruction pointers not captured");

    freeze_then_entry_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_stall ##1 i_handler_entry ##1 !o_stall);
    full_save_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        accept && kind == K_FULL_SAVE);
    restore_error_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        accept && st.load ##2 !o_error_n);
endmodule
`default_nettype wire

// [core/fpu_exc_pkg.sv]
// Notes on behaviour
// RQ1 - push to a full slot or pop from an empty one sets stack fault and invalid flag
// RQ2 - unmasked exception stays pending; freeze before next waiting instruction, call handler
// RQ3 - no freeze while ignore-error input is asserted or for no-wait instruction forms
// RQ4 - handler may be entered anywhere between detection and the next waiting instruction
// RQ5 - handler entry via maskable, non-maskable or management interrupt disables interrupts
// RQ6 - full save outputs whole state then reinitialises; environment save masks all
// RQ7 - loading an image with an unmasked flag set raises a new request at once
// RQ8 - full-state save image is 108 bytes
// RQ9 - environment-only save image is 28 bytes
// RQ10 - software reserves 512 bytes, 16-byte aligned, for the extended state save
// RQ11 - each numeric instruction start records instruction and operand pointers
// RQ12 - unmasked pending exception drives the active-low error line
// RQ13 - flags and error line hold until clear, reinitialisation or clean state load; here masking the flags also releases the error line
`default_nettype none
package fpu_exc_pkg;
    localparam int unsigned NUM_FLAGS       = 6;
    localparam int unsigned FLAG_INVALID    = 0;
    localparam logic [5:0]  MASK_ALL        = 6'h3F;
    localparam logic [5:0]  FLAGS_CLEAR     = 6'h00;
    localparam logic [9:0]  FULL_SAVE_BYTES = 10'h06C;
    localparam logic [9:0]  ENV_SAVE_BYTES  = 10'h01C;
    localparam logic [9:0]  EXT_SAVE_BYTES  = 10'h200;
    localparam logic [9:0]  NO_SAVE_BYTES   = 10'h000;
    localparam int unsigned SW_SF_BIT       = 6;
    localparam logic [7:0]  SW_UPPER_ZERO   = 8'h00;
    localparam logic [31:0] PTR_RESET       = 32'h0000_0000;

    typedef enum logic [3:0] {
        K_ARITH        = 4'h0,
        K_WAIT         = 4'h1,
        K_LOAD_CTRL    = 4'h2,
        K_CLEAR        = 4'h3,
        K_INIT         = 4'h4,
        K_FULL_SAVE    = 4'h5,
        K_ENV_SAVE     = 4'h6,
        K_EXT_SAVE     = 4'h7,
        K_FULL_RESTORE = 4'h8,
        K_ENV_RESTORE  = 4'h9,
        K_STORE_STATUS = 4'hA
    } insn_kind_e;

    typedef enum logic [1:0] {
        SRC_NONE      = 2'h0,
        SRC_MASKABLE  = 2'h1,
        SRC_NONMASK   = 2'h2,
        SRC_MGMT      = 2'h3
    } entry_src_e;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b01,
        ST_FROZEN = 2'b10
    } freeze_state_e;

    // waiting forms check for a pending exception before they execute
    function automatic logic is_waiting(input insn_kind_e k);
        is_waiting = (k == K_ARITH) || (k == K_WAIT) || (k == K_LOAD_CTRL) ||
                     (k == K_FULL_RESTORE) || (k == K_ENV_RESTORE);
    endfunction
endpackage
`default_nettype wire

// [core/status_if.sv]
`default_nettype none
interface status_if;
    import fpu_exc_pkg::*;
    logic                 detect;
    logic [NUM_FLAGS-1:0] detect_flags;
    logic                 set_stack_fault;
    logic                 clear_flags;
    logic                 reinit;
    logic                 mask_all;
    logic                 load;
    logic [NUM_FLAGS-1:0] load_flags;
    logic                 load_sf;
    logic                 load_masks_en;
    logic [NUM_FLAGS-1:0] load_masks;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] masks;
    logic                 stack_fault;
    logic                 pending;

    modport ctrl (
        output detect, detect_flags, set_stack_fault, clear_flags, reinit, mask_all,
        output load, load_flags, load_sf, load_masks_en, load_masks,
        input  flags, masks, stack_fault, pending
    );
    modport keeper (
        input  detect, detect_flags, set_stack_fault, clear_flags, reinit, mask_all,
        input  load, load_flags, load_sf, load_masks_en, load_masks,
        output flags, masks, stack_fault, pending
    );
endinterface
`default_nettype wire

// [core/exception_status.sv]
`default_nettype none
module exception_status
    import fpu_exc_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // status commands and state
    status_if.keeper  st
);
    logic [NUM_FLAGS-1:0] next_flags;
    logic                 next_sf;
    logic [NUM_FLAGS-1:0] base_flags;
    logic                 base_sf;

    // a detection in the same cycle as a clear survives it
    always_comb
    begin
        base_flags = st.flags;
        base_sf    = st.stack_fault;
        if (st.clear_flags || st.reinit)
        begin
            base_flags = FLAGS_CLEAR;
            base_sf    = 1'b0;
        end
        else if (st.load)
        begin
            base_flags = st.load_flags;
            base_sf    = st.load_sf;
        end
        next_flags = base_flags | (st.detect ? st.detect_flags : FLAGS_CLEAR);
        next_sf    = base_sf | st.set_stack_fault; // RQ1
        if (st.set_stack_fault)
        begin
            next_flags[FLAG_INVALID] = 1'b1; // RQ1
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st.flags       <= FLAGS_CLEAR;
            st.stack_fault <= 1'b0;
        end
        else
        begin
            st.flags       <= next_flags; // RQ13
            st.stack_fault <= next_sf;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st.masks <= MASK_ALL;
        end
        else if (st.reinit || st.mask_all)
        begin
            st.masks <= MASK_ALL; // RQ6
        end
        else if (st.load || st.load_masks_en)
        begin
            st.masks <= st.load_masks;
        end
    end

    assign st.pending = |(st.flags & ~st.masks); // RQ2

    stack_fault_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ1
        st.set_stack_fault |=> st.stack_fault && st.flags[FLAG_INVALID])
        else $error("stack fault did not set flag and invalid exception");
    flags_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ13
        !(st.clear_flags || st.reinit || st.load) |=>
            ((st.flags & $past(st.flags)) == $past(st.flags)))
        else $error("exception flag dropped without a clear");
endmodule
`default_nettype wire

// [tb/core_model.sv]
`default_nettype none
module core_model
    import fpu_exc_pkg::*;
(
    // clock
    input  wire logic       i_clk,
    // answers from the unit
    input  wire logic       i_insn_done,
    input  wire logic       i_stall,
    // instruction issue
    output var logic        o_insn_valid,
    output var logic [3:0]  o_insn_kind,
    output var logic [31:0] o_insn_ptr,
    output var logic [31:0] o_operand_ptr,
    // handler entry
    output var logic        o_handler_entry,
    output var logic [1:0]  o_entry_src
);
    timeunit 1ns;
    timeprecision 1ns;
    // extended save area, 512 bytes on a 16-byte boundary
    localparam logic [31:0] EXT_AREA = 32'h0000_2000;

    initial
    begin
        o_insn_valid    = 1'b0;
        o_insn_kind     = 4'hF;
        o_insn_ptr      = 32'hA5A5_A5A5;
        o_operand_ptr   = 32'h5A5A_5A5A;
        o_handler_entry = 1'b0;
        o_entry_src     = 2'h2;
    end

    // released lines show the inverse of their last value
    task automatic release_bus();
        o_insn_valid  = 1'b0;
        o_insn_kind   = ~o_insn_kind;
        o_insn_ptr    = ~o_insn_ptr;
        o_operand_ptr = ~o_operand_ptr;
    endtask

    // hold the request until done or a freeze; a frozen request stays up
    task automatic issue(input logic [3:0] kind, input logic [31:0] ip, output logic stalled);
        int n;
        @(posedge i_clk);
        #1;
        o_insn_kind   = kind;
        o_insn_ptr    = ip;
        o_operand_ptr = (kind == K_EXT_SAVE) ? EXT_AREA : ip + 32'h10;
        o_insn_valid  = 1'b1;
        n = 0;
        while (i_insn_done !== 1'b1 && i_stall !== 1'b1 && n < 20)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        stalled = (i_stall === 1'b1);
        if (!stalled)
            release_bus();
    endtask

    // enter the handler; a frozen instruction is dropped afterwards
    task automatic enter(input logic [1:0] src);
        o_handler_entry = 1'b1;
        o_entry_src     = src;
        @(posedge i_clk);
        #1;
        o_handler_entry = 1'b0;
        o_entry_src     = ~src;
        if (o_insn_valid)
            release_bus();
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top
    import fpu_exc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n, valid, done, stall, ovf, unf, det, ign_n, hent, ien;
    logic        hreq, intdis, err_n, sstr, st;
    logic [3:0]  kind;
    logic [1:0]  hsrc;
    logic [31:0] iptr, optr, ips, ops;
    logic [15:0] img_st, img_ct, sw;
    logic [5:0]  exc_flags, masks;
    logic [9:0]  sbytes;
    int          bad_count = 0;
    int          tests_run = 0;

    always #50 clk = ~clk;

    fpu_deferred_exception_signal fpu_deferred_exception_signal_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_insn_valid(valid), .i_insn_kind(kind),
        .i_insn_ptr(iptr), .i_operand_ptr(optr), .i_stack_overflow(ovf),
        .i_stack_underflow(unf), .i_image_status(img_st), .i_image_control(img_ct),
        .o_insn_done(done), .o_stall(stall), .i_exc_detect(det), .i_exc_flags(exc_flags),
        .i_ignore_numeric_error_n(ign_n), .i_handler_entry(hent), .i_entry_src(hsrc),
        .i_ext_int_enable(ien), .o_handler_request(hreq), .o_ext_int_disabled(intdis),
        .o_error_n(err_n), .o_status_word(sw), .o_control_masks(masks),
        .o_insn_ptr_saved(ips), .o_operand_ptr_saved(ops), .o_save_strobe(sstr),
        .o_save_bytes(sbytes));

    core_model core_model_i (
        .i_clk(clk), .i_insn_done(done), .i_stall(stall), .o_insn_valid(valid),
        .o_insn_kind(kind), .o_insn_ptr(iptr), .o_operand_ptr(optr),
        .o_handler_entry(hent), .o_entry_src(hsrc));

    task automatic results();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic run(input logic [3:0] k, input logic [31:0] ip, input logic exp_stall);
        core_model_i.issue(k, ip, st);
        chk(32'(st), 32'(exp_stall));
        chk(32'(st ? stall : done), 32'h1);
    endtask

    task automatic detect(input logic [5:0] f);
        det = 1'b1;
        exc_flags = f;
        step();
        det = 1'b0;
        exc_flags = ~f;
        step();
    endtask

    task automatic t_stack();
        img_ct = 16'h0000;
        run(K_LOAD_CTRL, 32'h0, 1'b0);
        step();
        chk(32'(masks), 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            ovf = (i == 0);
            unf = (i == 1);
            run(K_ARITH, 32'h0000_1234 + i, 1'b0);
            ovf = 1'b0;
            unf = 1'b0;
            step();
            chk(32'(sw), 32'h00C1);
            chk(ips, 32'h0000_1234 + i);
            chk(ops, 32'h0000_1244 + i);
            step();
            chk(32'(err_n), 32'h0);
            run(K_CLEAR, 32'h0, 1'b0);
            step();
            step();
            chk(32'(err_n), 32'h1);
            chk(32'(sw), 32'h0);
        end
    endtask

    task automatic t_freeze();
        detect(6'h01);
        step();
        chk(32'(err_n), 32'h0);
        ign_n = 1'b0;
        run(K_ARITH, 32'h0, 1'b0);
        ign_n = 1'b1;
        run(K_STORE_STATUS, 32'h0, 1'b0);
        for (int s = 1; s < 4; s++)
        begin
            run(K_WAIT, 32'h0, 1'b1);
            chk(32'(hreq), 32'h1);
            core_model_i.enter(2'(s));
            step();
            chk(32'(stall), 32'h0);
            chk(32'(intdis), 32'h1);
            chk(32'(err_n), 32'h0);
            ien = 1'b1;
            step();
            ien = 1'b0;
            step();
            chk(32'(intdis), 32'h0);
        end
        core_model_i.enter(2'h1);
        step();
        chk(32'(intdis), 32'h1);
        chk(32'(stall), 32'h0);
        ien = 1'b1;
        step();
        ien = 1'b0;
        core_model_i.enter(2'h0);
        step();
        chk(32'(intdis), 32'h0);
        run(K_CLEAR, 32'h0, 1'b0);
    endtask

    task automatic t_save();
        detect(6'h04);
        run(K_ENV_SAVE, 32'h0, 1'b0);
        chk(32'(sbytes), 32'd28);
        chk(32'(sstr), 32'h1);
        step();
        chk(32'(masks), 32'h3F);
        chk(32'(sw[5:0]), 32'h04);
        step();
        chk(32'(err_n), 32'h1);
        run(K_FULL_SAVE, 32'h0, 1'b0);
        chk(32'(sbytes), 32'd108);
        step();
        chk(32'(sw[6:0]), 32'h0);
        chk(32'(masks), 32'h3F);
        run(K_EXT_SAVE, 32'h0, 1'b0);
        chk(32'(sbytes), 32'd512);
        step();
        chk(32'(sstr), 32'h0);
    endtask

    task automatic t_restore();
        img_st = 16'h0001;
        img_ct = 16'h003E;
        run(K_FULL_RESTORE, 32'h0, 1'b0);
        step();
        chk(32'(sw[6:0]), 32'h01);
        chk(32'(masks), 32'h3E);
        step();
        chk(32'(err_n), 32'h0);
        img_st = 16'h0040;
        img_ct = 16'h003F;
        ign_n = 1'b0;
        run(K_ENV_RESTORE, 32'h0, 1'b0);
        ign_n = 1'b1;
        step();
        step();
        chk(32'(sw[6:0]), 32'h40);
        chk(32'(err_n), 32'h1);
        detect(6'h02);
        chk(32'(sw[6:0]), 32'h42);
        run(K_INIT, 32'h0, 1'b0);
        step();
        chk(32'(sw), 32'h0);
    endtask

    initial
    begin
        rst_n = 1'b0;
        ovf = 1'b0;
        unf = 1'b0;
        det = 1'b0;
        exc_flags = 6'h00;
        ign_n = 1'b1;
        ien = 1'b0;
        img_st = 16'h0000;
        img_ct = 16'h003F;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(32'(sw), 32'h0);
        chk(32'(err_n), 32'h1);
        chk(32'(masks), 32'h3F);
        t_stack();
        t_freeze();
        t_save();
        t_restore();
        results();
    end

    // cut a hang short well beyond the fewer than a hundred cycles the tests need
    initial
    begin
        #(3000 * 100);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
